/* dpll_loop_state_controller.sv */
// Loop control state machine with APB register access
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`include "loop_ctrl_defines.svh"
module dpll_loop_state_controller (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  // Byte address; the loop mode word sits above the 12-bit range
  input wire logic [13:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Reference monitors and automatic selection
  input wire logic [3:0] REF_VALID,
  input wire logic [1:0] AUTO_REF,
  // Loop filter, history and lock detectors
  input wire logic [47:0] LOOP_FTW,
  input wire logic [47:0] HIST_FTW,
  input wire logic HIST_EXISTS,
  input wire logic PHASE_LOCK_IN,
  input wire logic FREQ_LOCK_IN,
  // DDS and loop control
  output logic [47:0] DDS_FTW,
  output logic LOOP_OPEN,
  output logic [1:0] ACTIVE_REF,
  output logic PROFILE_LOAD,
  output logic [1:0] PROFILE_STEP,
  output logic PHASE_LOCK,
  output logic FREQ_LOCK,
  output logic [2:0] LOOP_STATE
);
  loop_ctrl_pkg::loop_state_type state;
  loop_ctrl_pkg::loop_state_type next_state;
  loop_ctrl_pkg::profile_cmd_type prof;
  logic [47:0] free_run_tuning_word;
  logic [7:0] history_mode;
  logic [7:0] loop_mode;
  logic [23:0] clamp_lo;
  logic [23:0] clamp_hi;
  logic [47:0] hold_ftw;
  logic [47:0] raw_ftw;
  logic [47:0] lim_lo;
  logic [47:0] lim_hi;
  logic [1:0] sel_ref;
  logic [1:0] step_cnt;
  logic sel_valid;
  logic user_hold;
  logic user_free;
  logic wr_en;
  logic rd_en;

  // Address decode used by both write and read paths
  function automatic logic mapped(input logic [13:0] a);
    mapped = (a == `FTW_LO_ADDR) || (a == `FTW_HI_ADDR) || (a == `HIST_MODE_ADDR)
      || (a == `LOOP_MODE_ADDR) || (a == `CLAMP_LO_ADDR) || (a == `CLAMP_HI_ADDR)
      || (a == `STATUS_ADDR);
  endfunction : mapped

  assign wr_en = PSEL && PENABLE && PWRITE && mapped(PADDR);
  assign rd_en = PSEL && !PENABLE && !PWRITE;

  assign user_hold = loop_mode[`USER_HOLDOVER_BIT];
  assign user_free = loop_mode[`USER_FREERUN_BIT];

  assign sel_ref = loop_mode[`FORCE_REF_EN_BIT] ? loop_mode[`FORCE_REF_SEL_LSB +: 2] : AUTO_REF;
  assign sel_valid = REF_VALID[sel_ref];

  // Register writes; one wait-free access phase
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      free_run_tuning_word <= `FTW_RESET;
      history_mode <= 8'h00;
      loop_mode <= 8'h00;
      clamp_lo <= `CLAMP_LO_RESET;
      clamp_hi <= `CLAMP_HI_RESET;
    end else if (wr_en) begin
      unique case (PADDR)
        `FTW_LO_ADDR: free_run_tuning_word[31:0] <= PWDATA;
        `FTW_HI_ADDR: free_run_tuning_word[47:32] <= PWDATA[15:0];
        `HIST_MODE_ADDR: history_mode <= PWDATA[7:0];
        `LOOP_MODE_ADDR: loop_mode <= PWDATA[7:0];
        `CLAMP_LO_ADDR: clamp_lo <= PWDATA[23:0];
        `CLAMP_HI_ADDR: clamp_hi <= PWDATA[23:0];
        default: ;
      endcase
    end
  end

  // Read data is captured in setup so it is registered during access
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      PREADY <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped(PADDR);
      if (rd_en) begin
        unique case (PADDR)
          `FTW_LO_ADDR: PRDATA <= free_run_tuning_word[31:0];
          `FTW_HI_ADDR: PRDATA <= {16'h0000, free_run_tuning_word[47:32]};
          `HIST_MODE_ADDR: PRDATA <= {24'h00_0000, history_mode};
          `LOOP_MODE_ADDR: PRDATA <= {24'h00_0000, loop_mode};
          `CLAMP_LO_ADDR: PRDATA <= {8'h00, clamp_lo};
          `CLAMP_HI_ADDR: PRDATA <= {8'h00, clamp_hi};
          `STATUS_ADDR: PRDATA <= {25'h000_0000, ACTIVE_REF, 2'h0, LOOP_STATE};
          default: PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      loop_ctrl_pkg::ST_FREE: begin
        if (!user_free && !user_hold && sel_valid) begin
          next_state = loop_ctrl_pkg::ST_RECOVER;
        end else if (!user_free && user_hold) begin
          next_state = loop_ctrl_pkg::ST_HOLD;
        end
      end
      loop_ctrl_pkg::ST_CLOSED: begin
        if (user_free) begin
          next_state = loop_ctrl_pkg::ST_FREE;
        end else if (user_hold || !REF_VALID[ACTIVE_REF]) begin
          next_state = loop_ctrl_pkg::ST_HOLD;
        end else if (sel_ref != ACTIVE_REF && sel_valid) begin
          next_state = loop_ctrl_pkg::ST_SWITCH;
        end
      end
      loop_ctrl_pkg::ST_HOLD: begin
        if (user_free) begin
          next_state = loop_ctrl_pkg::ST_FREE;
        end else if (!user_hold && sel_valid) begin
          next_state = loop_ctrl_pkg::ST_RECOVER;
        end
      end
      loop_ctrl_pkg::ST_SWITCH: next_state = loop_ctrl_pkg::ST_RECOVER;
      loop_ctrl_pkg::ST_RECOVER: begin
        if (user_free) begin
          next_state = loop_ctrl_pkg::ST_FREE;
        end else if (user_hold || !sel_valid) begin
          next_state = loop_ctrl_pkg::ST_HOLD;
        end else if (step_cnt == `RECOVER_STEPS) begin
          next_state = loop_ctrl_pkg::ST_CLOSED;
        end
      end
      default: next_state = loop_ctrl_pkg::ST_FREE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state <= loop_ctrl_pkg::ST_FREE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      step_cnt <= 2'h0;
    end else if (state == loop_ctrl_pkg::ST_RECOVER && step_cnt != `RECOVER_STEPS) begin
      step_cnt <= step_cnt + 2'h1;
    end else if (state != loop_ctrl_pkg::ST_RECOVER) begin
      step_cnt <= 2'h0;
    end
  end

  // profile load on each state change
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ACTIVE_REF <= 2'h0;
      PROFILE_LOAD <= 1'b0;
      PROFILE_STEP <= 2'h0;
      prof <= '0;
    end else begin
      prof.load <= next_state != state || state == loop_ctrl_pkg::ST_RECOVER;
      prof.step <= step_cnt;
      prof.sel <= sel_ref;
      PROFILE_LOAD <= next_state != state || state == loop_ctrl_pkg::ST_RECOVER;
      PROFILE_STEP <= step_cnt;
      if (next_state == loop_ctrl_pkg::ST_RECOVER && state != loop_ctrl_pkg::ST_RECOVER) begin
        ACTIVE_REF <= sel_ref;
      end
    end
  end

  // holdover word captured at entry, full width
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      hold_ftw <= `FTW_RESET;
    end else if ((next_state == loop_ctrl_pkg::ST_HOLD || next_state == loop_ctrl_pkg::ST_SWITCH)
        && state != loop_ctrl_pkg::ST_HOLD && state != loop_ctrl_pkg::ST_SWITCH) begin
      if (HIST_EXISTS) begin
        hold_ftw <= HIST_FTW;
      end else if (history_mode[`HIST_FALLBACK_BIT]) begin
        hold_ftw <= DDS_FTW;
      end else begin
        hold_ftw <= free_run_tuning_word;
      end
    end
  end

  always_comb begin
    unique case (state)
      loop_ctrl_pkg::ST_FREE: raw_ftw = free_run_tuning_word;
      loop_ctrl_pkg::ST_HOLD, loop_ctrl_pkg::ST_SWITCH: raw_ftw = hold_ftw;
      default: raw_ftw = LOOP_FTW;
    endcase
  end

  // Clamp limits have 24-bit granularity on the top of the word
  assign lim_lo = {clamp_lo, 24'h00_0000};
  assign lim_hi = {clamp_hi, 24'hFF_FFFF};

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      DDS_FTW <= `FTW_RESET;
      LOOP_OPEN <= 1'b1;
      LOOP_STATE <= 3'h0;
    end else begin
      if (raw_ftw < lim_lo) begin
        DDS_FTW <= lim_lo;
      end else if (raw_ftw > lim_hi) begin
        DDS_FTW <= lim_hi;
      end else begin
        DDS_FTW <= raw_ftw;
      end
      LOOP_OPEN <= state == loop_ctrl_pkg::ST_FREE || state == loop_ctrl_pkg::ST_HOLD
        || state == loop_ctrl_pkg::ST_SWITCH;
      LOOP_STATE <= state;
    end
  end

  // hold lock flags through a switchover
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PHASE_LOCK <= 1'b0;
      FREQ_LOCK <= 1'b0;
    end else if (state != loop_ctrl_pkg::ST_SWITCH
        && !(state == loop_ctrl_pkg::ST_RECOVER && prof.sel != ACTIVE_REF)) begin
      PHASE_LOCK <= PHASE_LOCK_IN;
      FREQ_LOCK <= FREQ_LOCK_IN;
    end
  end
endmodule : dpll_loop_state_controller

/* dpll_loop_state_controller_bench.sv */
// Self-checking bench of the loop state controller
`timescale 1ns/1ns
`include "loop_ctrl_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module dpll_loop_state_controller_bench;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [13:0] PADDR = 14'h0000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, HIST_EXISTS, PHASE_LOCK_IN, FREQ_LOCK_IN;
  logic LOOP_OPEN, PROFILE_LOAD, PHASE_LOCK, FREQ_LOCK, steady = 1'b0, hist_on = 1'b0;
  logic [3:0] REF_VALID;
  logic [1:0] AUTO_REF, ACTIVE_REF, PROFILE_STEP;
  logic [2:0] LOOP_STATE;
  logic [47:0] LOOP_FTW, HIST_FTW, DDS_FTW, ftw, word = 48'h0, hist = 48'h0;
  logic [33:0] notes[$];
  logic [33:0] n;
  int fails = 0;
  int samples_checked = 0;
  dpll_loop_state_controller dut_u (.CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .REF_VALID, .AUTO_REF, .LOOP_FTW, .HIST_FTW, .HIST_EXISTS,
    .PHASE_LOCK_IN, .FREQ_LOCK_IN, .DDS_FTW, .LOOP_OPEN, .ACTIVE_REF, .PROFILE_LOAD,
    .PROFILE_STEP, .PHASE_LOCK, .FREQ_LOCK, .LOOP_STATE);
  loop_partner model_u (.CORE_CLK, .RST, .steady, .hist_on, .steady_word(word),
    .hist_word(hist), .REF_VALID, .AUTO_REF, .LOOP_FTW, .HIST_FTW, .HIST_EXISTS,
    .PHASE_LOCK_IN, .FREQ_LOCK_IN);
  initial forever #5 CORE_CLK = ~CORE_CLK;
  task report_and_stop;
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // Request held until the edge where ready is sampled
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d, input logic e);
    int i;
    i = 0;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    notes.push_back({wr, e, e ? 32'h0 : d});
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin @(posedge CORE_CLK); i++; end while (PREADY !== 1'b1 && i < 20);
    if (PREADY !== 1'b1) fails++;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic wait_state(input logic [2:0] s);
    int i;
    i = 0;
    do begin @(posedge CORE_CLK); i++; end while (LOOP_STATE !== s && i < 40);
    `CHK(LOOP_STATE, s)
  endtask : wait_state
  always @(posedge CORE_CLK) begin
    if (PREADY === 1'b1 && PSEL && PENABLE && notes.size() > 0) begin
      n = notes.pop_front();
      `CHK(PSLVERR, n[32])
      if (!n[33]) `CHK(PRDATA, n[31:0])
    end
  end
  initial begin
    #200000;
    fails++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h6A3E));
    ftw = {1'b1, 15'($urandom()), $urandom()};
    word = {16'($urandom()), $urandom()};
    hist = {16'($urandom()), $urandom()};
    repeat (8) @(posedge CORE_CLK);
    RST <= 1'b0;
    apb(1'b0, `CLAMP_HI_ADDR, 32'(`CLAMP_HI_RESET), 1'b0);
    apb(1'b0, 14'h00FC, 32'h0, 1'b1);
    apb(1'b1, `FTW_LO_ADDR, ftw[31:0], 1'b0);
    apb(1'b1, `FTW_HI_ADDR, 32'(ftw[47:32]), 1'b0);
    apb(1'b1, `LOOP_MODE_ADDR, 32'h20, 1'b0);
    apb(1'b0, `LOOP_MODE_ADDR, 32'h20, 1'b0);
    wait_state(3'h0);
    repeat (2) @(posedge CORE_CLK);
    `CHK(DDS_FTW, ftw)
    apb(1'b1, `CLAMP_HI_ADDR, 32'(ftw[47:24] - 24'h1), 1'b0);
    repeat (2) @(posedge CORE_CLK);
    `CHK(DDS_FTW[47:24], ftw[47:24] - 24'h1)
    apb(1'b1, `CLAMP_HI_ADDR, 32'(`CLAMP_HI_RESET), 1'b0);
    steady <= 1'b1;
    // Three holdover sources: free-run word, last word, history
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `LOOP_MODE_ADDR, 32'h0, 1'b0);
      wait_state(3'h1);
      hist_on <= (k == 2);
      apb(1'b1, `HIST_MODE_ADDR, k == 1 ? 32'h10 : 32'h0, 1'b0);
      apb(1'b1, `LOOP_MODE_ADDR, 32'h40, 1'b0);
      wait_state(3'h3);
      repeat (3) @(posedge CORE_CLK);
      `CHK(DDS_FTW, k == 0 ? ftw : k == 1 ? word : hist)
      `CHK(LOOP_STATE, 3'h3)
    end
    apb(1'b1, `LOOP_MODE_ADDR, 32'h0, 1'b0);
    wait_state(3'h1);
    `CHK(ACTIVE_REF, 2'h0)
    apb(1'b1, `LOOP_MODE_ADDR, 32'h06, 1'b0);
    wait_state(3'h2);
    wait_state(3'h6);
    wait_state(3'h1);
    `CHK(ACTIVE_REF, 2'h2)
    apb(1'b0, `STATUS_ADDR, 32'h41, 1'b0);
    // Let the watcher take the last answer before closing
    @(posedge CORE_CLK);
    report_and_stop;
  end
endmodule : dpll_loop_state_controller_bench

/* loop_ctrl_defines.svh */
// Register offsets, field positions and reset values of the loop state controller
// Behaviour
// - Controller moves between references and holdover automatically from monitored validity.
// - On each state change, apply profile coefficients, dividers and offsets of the reference.
// - Software forces holdover or free-run through the loop mode register.
// - Software can force one reference, overriding the automatic choice.
// - Reference switch runs as a brief holdover then immediate recovery.
// - Lock detector outputs freeze at prior values during switchover.
// - Holdover runs open loop with a constant tuning word.
// - With history present, holdover uses the latest averaged history word.
// - No history and fallback clear: holdover uses the free-run tuning word.
// - No history and fallback set: holdover keeps the last instantaneous word.
// - In holdover, a valid reference brings the loop back closed and locked.
// - Recovery restores loop parameters step by step from the active profile.
// - User holdover bit keeps the loop in holdover despite a valid reference.
// - Clearing the user holdover bit resumes automatic recovery.
// - Holdover tuning word keeps full 48-bit resolution.
// - Free-run tuning word comes from the free-run tuning word register.
// - Closed loop takes the tuning word from the loop filter output.
// - Tuning word always stays between the upper and lower clamp limits.
`ifndef LOOP_CTRL_DEFINES_SVH
`define LOOP_CTRL_DEFINES_SVH

`define FTW_LO_ADDR 14'h0C00
`define FTW_HI_ADDR 14'h0C04
`define HIST_MODE_ADDR 14'h0C6C
`define LOOP_MODE_ADDR 14'h2804
`define CLAMP_LO_ADDR 14'h0010
`define CLAMP_HI_ADDR 14'h0014
`define STATUS_ADDR 14'h0018
`define FTW_REG_IDX 12'h300
`define HIST_MODE_REG_IDX 12'h31B
`define LOOP_MODE_REG_IDX 12'hA01
`define HIST_FALLBACK_BIT 4
`define USER_HOLDOVER_BIT 6
`define USER_FREERUN_BIT 5
`define FORCE_REF_EN_BIT 2
`define FORCE_REF_SEL_LSB 0
`define FTW_RESET 48'h0000_0000_0000
`define CLAMP_LO_RESET 24'h00_0000
`define CLAMP_HI_RESET 24'hFF_FFFF
`define RECOVER_STEPS 2'h3

`endif

/* loop_ctrl_pkg.sv */
// Types shared by the loop state controller
package loop_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_FREE = 3'h0,
    ST_CLOSED = 3'h1,
    ST_HOLD = 3'h3,
    ST_SWITCH = 3'h2,
    ST_RECOVER = 3'h6
  } loop_state_type;

  typedef struct packed {
    logic paddr_sel;
    logic [13:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [1:0] sel;
    logic [1:0] step;
    logic load;
  } profile_cmd_type;
endpackage : loop_ctrl_pkg

/* loop_ctrl_properties.sv */
// Port checker of the loop state controller
`timescale 1ns/1ns
module loop_ctrl_properties (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Watched ports
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic [47:0] LOOP_FTW,
  input wire logic [47:0] DDS_FTW,
  input wire logic LOOP_OPEN,
  input wire logic PROFILE_LOAD,
  input wire logic PHASE_LOCK,
  input wire logic FREQ_LOCK,
  input wire logic [2:0] LOOP_STATE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  ready_pulse_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("ready is not a single pulse after setup");
  hold_open_a: assert property (LOOP_STATE == 3'h3 |-> LOOP_OPEN)
    else $error("loop closed while in holdover");
  hold_const_a: assert property ((LOOP_STATE == 3'h3) [*2] |-> $stable(DDS_FTW))
    else $error("tuning word moved in holdover");
  closed_word_a: assert property (LOOP_STATE == 3'h1 |-> DDS_FTW == $past(LOOP_FTW))
    else $error("closed loop word is not the filter word");
  lock_freeze_a: assert property (LOOP_STATE == 3'h2 |-> $stable({PHASE_LOCK, FREQ_LOCK}))
    else $error("lock flags moved during switchover");
  switch_short_a: assert property (LOOP_STATE == 3'h2 |=> LOOP_STATE == 3'h6)
    else $error("switchover did not pass straight to recovery");
  recover_seq_a: assert property ($rose(LOOP_STATE == 3'h6) |->
    (LOOP_STATE == 3'h6) [*4] ##1 LOOP_STATE == 3'h1)
    else $error("recovery length wrong");
  profile_load_a: assert property ($changed(LOOP_STATE) |-> $past(PROFILE_LOAD))
    else $error("no profile load on state change");
  cover property (LOOP_STATE == 3'h2);
  cover property (LOOP_STATE == 3'h3 && LOOP_OPEN);
  cover property ($rose(LOOP_STATE == 3'h1));
endmodule : loop_ctrl_properties

bind dpll_loop_state_controller loop_ctrl_properties chk_u (.CORE_CLK(CORE_CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .LOOP_FTW(LOOP_FTW), .DDS_FTW(DDS_FTW),
  .LOOP_OPEN(LOOP_OPEN), .PROFILE_LOAD(PROFILE_LOAD), .PHASE_LOCK(PHASE_LOCK),
  .FREQ_LOCK(FREQ_LOCK), .LOOP_STATE(LOOP_STATE));

/* loop_partner.sv */
// Model of the loop filter, history unit and reference monitors
`timescale 1ns/1ns
module loop_partner (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Bench control
  input wire logic steady,
  input wire logic hist_on,
  input wire logic [47:0] steady_word,
  input wire logic [47:0] hist_word,
  // Toward the controller
  output logic [3:0] REF_VALID,
  output logic [1:0] AUTO_REF,
  output logic [47:0] LOOP_FTW,
  output logic [47:0] HIST_FTW,
  output logic HIST_EXISTS,
  output logic PHASE_LOCK_IN,
  output logic FREQ_LOCK_IN
);
  initial LOOP_FTW = 48'h0000_0000_0000;
  initial PHASE_LOCK_IN = 1'b0;
  initial FREQ_LOCK_IN = 1'b0;
  // Word wanders every cycle while steady is low, so a stale or late copy is caught
  always @(posedge CORE_CLK) begin
    LOOP_FTW <= steady ? steady_word : 48'({$urandom(), $urandom()});
    PHASE_LOCK_IN <= 1'($urandom());
    FREQ_LOCK_IN <= 1'($urandom());
  end
  assign REF_VALID = 4'hF;
  assign AUTO_REF = 2'h0;
  assign HIST_FTW = hist_word;
  assign HIST_EXISTS = hist_on;
endmodule : loop_partner
